// File: core/preset_status_consts.svh
// offsets, field positions, reset values and decode values for preset/status
// Overview of operation
// - filter select bit: 0 normal 70 deg margin, 1 high 88.5 deg margin
// - bandwidth code 00 50 Hz, 01 1 Hz, 10 10 Hz, 11 100 Hz
// - tolerance code outer: 10%, 12 ppm, 48 ppm, 200 ppm
// - tolerance code inner: 8%, 9.6 ppm, 38 ppm, 160 ppm
// - writing 1 to load trigger starts ROM download, map untouched
// - load trigger clears itself when ROM download finishes
// - reset trigger soft-resets part, starts ROM download, clears when done
// - status readback registers are read-only, writes ignored
// - software writes 0x01 to update strobe; status refreshes from live state
// - memory status bit 3 set while ROM is being read
// - memory status bit 2 set on nonvolatile save or load error
// - bit 1 set while nonvolatile read, bit 0 while nonvolatile write
// - clock status bit 6: digital and output loops both locked
// - clock status bit 5: multiplier, output and digital loops all locked
// - clock status bit 4: output oscillator running correctly
// - clock status bit 3 set while output oscillator calibrates
// - clock status bit 2: output loop lock
// - clock status bit 1: system clock stability timer expired
// - clock status bit 0: multiplier lock
// - event bit set on its event unless masked
// - event bits sticky until per-event clear, clear-all, or reset
// - digital loop events bits 7..0: switch, closed, free, hold, freq, phase
`ifndef PRESET_STATUS_CONSTS_SVH
`define PRESET_STATUS_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_UPDATE_STROBE 12'h005
`define IDX_EVENT_MASK 12'h20A
`define IDX_EVENT_CONTROL 12'hA03
`define IDX_EVENT_CLEAR 12'hA06
`define IDX_PRESET_LOOP_SETTINGS 12'hC06
`define IDX_PRESET_LOAD_TRIGGER 12'hC07
`define IDX_PRESET_RESET_TRIGGER 12'hC08
`define IDX_MEMORY_STATUS 12'hD00
`define IDX_CLOCK_STATUS 12'hD01
`define IDX_STATUS_FIRST 12'hD00
`define IDX_STATUS_LAST 12'hD14
`define IDX_DIGITAL_EVENTS 12'hD04

`define UPDATE_STROBE_VALUE 8'h01
`define CLEAR_ALL_BIT 1
`define FILTER_SEL_BIT 4
`define BW_MSB 3
`define BW_LSB 2
`define TOL_MSB 1
`define TOL_LSB 0
`define TRIGGER_BIT 0

`define LOOP_SETTINGS_RESET 8'h00
`define EVENT_MASK_RESET 8'h00

// memory status bits
`define MEM_ROM_READ_BIT 3
`define MEM_FAULT_BIT 2
`define MEM_LOAD_BIT 1
`define MEM_SAVE_BIT 0
// clock status bits
`define CLK_DIG_OUT_LOCK_BIT 6
`define CLK_ALL_LOCK_BIT 5
`define CLK_OSC_OK_BIT 4
`define CLK_CAL_BIT 3
`define CLK_OUT_LOCK_BIT 2
`define CLK_STABLE_BIT 1
`define CLK_MULT_LOCK_BIT 0

// decoded settings
`define MARGIN_NORMAL_TENTHS_DEG 12'h2BC
`define MARGIN_HIGH_TENTHS_DEG 12'h375
`define BW_CODE00_HZ 8'h32
`define BW_CODE01_HZ 8'h01
`define BW_CODE10_HZ 8'h0A
`define BW_CODE11_HZ 8'h64
`define OUTER_TOL00_PPB 32'h05F5_E100
`define OUTER_TOL01_PPB 32'h0000_2EE0
`define OUTER_TOL10_PPB 32'h0000_BB80
`define OUTER_TOL11_PPB 32'h0003_0D40
`define INNER_TOL00_PPB 32'h04C4_B400
`define INNER_TOL01_PPB 32'h0000_2580
`define INNER_TOL10_PPB 32'h0000_9470
`define INNER_TOL11_PPB 32'h0002_7100

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/preset_status_pkg.sv
// types for the preset configuration and status block
package preset_status_pkg;
	typedef enum logic {ROM_IDLE, ROM_BUSY} rom_state_t;
	typedef logic [7:0] reg8_t;
endpackage

// File: core/preset_config_status_readback.sv
// preset configuration, ROM download triggers and status readback over AXI4-Lite
`include "preset_status_consts.svh"
module preset_config_status_readback (
	input wire logic I_CLK, // system clock, 10 MHz
	input wire logic I_RST, // synchronous reset, active high
	input wire logic [15:0] S_AXI_AWADDR, // write address, bytes
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte enables
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [15:0] S_AXI_ARADDR, // read address, bytes
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic I_ROM_DONE, // pulse: ROM download finished
	input wire logic I_NVM_LOAD_BUSY, // level: nonvolatile read running
	input wire logic I_NVM_SAVE_BUSY, // level: nonvolatile write running
	input wire logic I_NVM_FAULT, // level: nonvolatile save/load error
	input wire logic I_MULTIPLIER_LOCK, // system clock multiplier locked
	input wire logic I_OUTPUT_LOOP_LOCK, // output loop locked
	input wire logic I_DIGITAL_LOOP_LOCK, // digital loop locked
	input wire logic I_OUTPUT_OSCILLATOR_OK, // output oscillator running
	input wire logic I_OUTPUT_LOOP_CALIBRATING, // oscillator calibrating
	input wire logic I_STABILITY_TIMER_EXPIRED, // system clock stable
	input wire logic [7:0] I_DIGITAL_LOOP_EVENTS, // one-cycle event pulses
	output logic O_HIGH_MARGIN_FILTER_SELECT, // base loop filter select
	output logic [11:0] O_PHASE_MARGIN_TENTHS, // margin, tenths of degree
	output logic [1:0] O_LOOP_BANDWIDTH_CODE, // bandwidth code
	output logic [7:0] O_LOOP_BANDWIDTH_HZ, // decoded bandwidth, Hz
	output logic [1:0] O_TOLERANCE_CODE, // tolerance code
	output logic [31:0] O_OUTER_TOLERANCE_PPB, // outer tolerance, ppb
	output logic [31:0] O_INNER_TOLERANCE_PPB, // inner tolerance, ppb
	output logic O_ROM_LOAD_START, // pulse: begin ROM download
	output logic O_SOFT_RESET, // pulse: soft reset of the part
	output logic O_ROM_BUSY // ROM download under way
);
	// bus state
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [11:0] aw_idx_q, aw_idx_d;
	logic [7:0] wdata_q, wdata_d;
	logic wlane_q, wlane_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// register state
	preset_status_pkg::reg8_t settings_q, settings_d;
	preset_status_pkg::reg8_t mask_q, mask_d;
	logic load_trig_q, load_trig_d;
	logic reset_trig_q, reset_trig_d;
	preset_status_pkg::rom_state_t rom_q, rom_d;
	logic start_q, start_d;
	logic soft_rst_q, soft_rst_d;
	preset_status_pkg::reg8_t events_q, events_d;
	preset_status_pkg::reg8_t snap_mem_q, snap_mem_d;
	preset_status_pkg::reg8_t snap_clk_q, snap_clk_d;
	preset_status_pkg::reg8_t snap_evt_q, snap_evt_d;

	logic do_write;
	logic wr_on;
	logic [11:0] ar_idx;
	preset_status_pkg::reg8_t live_mem, live_clk, clr_mask, set_mask;

	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_on = do_write && wlane_q;
	assign ar_idx = S_AXI_ARADDR[13:2];

	// live status words
	always_comb
	begin
		live_mem = 8'h00;
		live_mem[`MEM_ROM_READ_BIT] = (rom_q == preset_status_pkg::ROM_BUSY);
		live_mem[`MEM_FAULT_BIT] = I_NVM_FAULT;
		live_mem[`MEM_LOAD_BIT] = I_NVM_LOAD_BUSY;
		live_mem[`MEM_SAVE_BIT] = I_NVM_SAVE_BUSY;
		live_clk = 8'h00;
		live_clk[`CLK_DIG_OUT_LOCK_BIT] =
			I_DIGITAL_LOOP_LOCK && I_OUTPUT_LOOP_LOCK;
		live_clk[`CLK_ALL_LOCK_BIT] = I_MULTIPLIER_LOCK &&
			I_OUTPUT_LOOP_LOCK && I_DIGITAL_LOOP_LOCK;
		live_clk[`CLK_OSC_OK_BIT] = I_OUTPUT_OSCILLATOR_OK;
		live_clk[`CLK_CAL_BIT] = I_OUTPUT_LOOP_CALIBRATING;
		live_clk[`CLK_OUT_LOCK_BIT] = I_OUTPUT_LOOP_LOCK;
		live_clk[`CLK_STABLE_BIT] = I_STABILITY_TIMER_EXPIRED;
		live_clk[`CLK_MULT_LOCK_BIT] = I_MULTIPLIER_LOCK;
	end

	// write channel: address and data taken in either order
	always_comb
	begin
		aw_held_d = aw_held_q;
		aw_idx_d = aw_idx_q;
		w_held_d = w_held_q;
		wdata_d = wdata_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_held_d = 1'b1;
			aw_idx_d = S_AXI_AWADDR[13:2];
		end
		if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_held_d = 1'b1;
			wdata_d = S_AXI_WDATA[7:0];
			wlane_d = S_AXI_WSTRB[0];
		end
		if (do_write)
		begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `RESP_OKAY;
			unique case (aw_idx_q)
				`IDX_UPDATE_STROBE, `IDX_EVENT_MASK, `IDX_EVENT_CONTROL,
				`IDX_EVENT_CLEAR, `IDX_PRESET_LOOP_SETTINGS,
				`IDX_PRESET_LOAD_TRIGGER, `IDX_PRESET_RESET_TRIGGER:
					bresp_d = `RESP_OKAY;
				default:
					// status range accepts and drops the write
					if (aw_idx_q < `IDX_STATUS_FIRST ||
						aw_idx_q > `IDX_STATUS_LAST)
						bresp_d = `RESP_SLVERR;
			endcase
		end
		else if (bvalid_q && S_AXI_BREADY)
			bvalid_d = 1'b0;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			aw_held_q <= 1'b0;
			aw_idx_q <= 12'h000;
			w_held_q <= 1'b0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			aw_idx_q <= aw_idx_d;
			w_held_q <= w_held_d;
			wdata_q <= wdata_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
	assign S_AXI_WREADY = !w_held_q && !bvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// configuration, triggers, ROM download sequencing
	always_comb
	begin
		settings_d = settings_q;
		mask_d = mask_q;
		load_trig_d = load_trig_q;
		reset_trig_d = reset_trig_q;
		rom_d = rom_q;
		start_d = 1'b0;
		soft_rst_d = 1'b0;
		if (wr_on && aw_idx_q == `IDX_PRESET_LOOP_SETTINGS)
			settings_d = {3'b000, wdata_q[4:0]};
		if (wr_on && aw_idx_q == `IDX_EVENT_MASK)
			mask_d = wdata_q;
		unique case (rom_q)
			preset_status_pkg::ROM_IDLE:
			begin
				// a trigger written during a download is ignored
				if (wr_on && aw_idx_q == `IDX_PRESET_LOAD_TRIGGER &&
					wdata_q[`TRIGGER_BIT])
				begin
					load_trig_d = 1'b1;
					start_d = 1'b1;
					rom_d = preset_status_pkg::ROM_BUSY;
				end
				else if (wr_on && aw_idx_q == `IDX_PRESET_RESET_TRIGGER &&
					wdata_q[`TRIGGER_BIT])
				begin
					reset_trig_d = 1'b1;
					soft_rst_d = 1'b1;
					start_d = 1'b1;
					rom_d = preset_status_pkg::ROM_BUSY;
				end
			end
			preset_status_pkg::ROM_BUSY:
				if (I_ROM_DONE)
				begin
					load_trig_d = 1'b0;
					reset_trig_d = 1'b0;
					rom_d = preset_status_pkg::ROM_IDLE;
				end
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			settings_q <= `LOOP_SETTINGS_RESET;
			mask_q <= `EVENT_MASK_RESET;
			load_trig_q <= 1'b0;
			reset_trig_q <= 1'b0;
			rom_q <= preset_status_pkg::ROM_IDLE;
			start_q <= 1'b0;
			soft_rst_q <= 1'b0;
		end
		else
		begin
			settings_q <= settings_d;
			mask_q <= mask_d;
			load_trig_q <= load_trig_d;
			reset_trig_q <= reset_trig_d;
			rom_q <= rom_d;
			start_q <= start_d;
			soft_rst_q <= soft_rst_d;
		end
	end

	// sticky digital loop events; a new event beats a clear in the same cycle
	always_comb
	begin
		clr_mask = 8'h00;
		if (wr_on && aw_idx_q == `IDX_EVENT_CLEAR)
			clr_mask = wdata_q;
		if (wr_on && aw_idx_q == `IDX_EVENT_CONTROL &&
			wdata_q[`CLEAR_ALL_BIT])
			clr_mask = 8'hFF;
		set_mask = I_DIGITAL_LOOP_EVENTS & ~mask_q;
		events_d = (events_q & ~clr_mask) | set_mask;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			events_q <= 8'h00;
		else
			events_q <= events_d;
	end

	// status snapshot, refreshed only by the update strobe
	always_comb
	begin
		snap_mem_d = snap_mem_q;
		snap_clk_d = snap_clk_q;
		snap_evt_d = snap_evt_q;
		if (wr_on && aw_idx_q == `IDX_UPDATE_STROBE &&
			wdata_q == `UPDATE_STROBE_VALUE)
		begin
			snap_mem_d = live_mem;
			snap_clk_d = live_clk;
			snap_evt_d = events_d;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			snap_mem_q <= 8'h00;
			snap_clk_q <= 8'h00;
			snap_evt_q <= 8'h00;
		end
		else
		begin
			snap_mem_q <= snap_mem_d;
			snap_clk_q <= snap_clk_d;
			snap_evt_q <= snap_evt_d;
		end
	end

	// read channel: data one cycle after the address is taken
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			rvalid_d = 1'b1;
			rresp_d = `RESP_OKAY;
			rdata_d = 32'h0000_0000;
			unique case (ar_idx)
				`IDX_PRESET_LOOP_SETTINGS: rdata_d[7:0] = settings_q;
				`IDX_PRESET_LOAD_TRIGGER: rdata_d[0] = load_trig_q;
				`IDX_PRESET_RESET_TRIGGER: rdata_d[0] = reset_trig_q;
				`IDX_EVENT_MASK: rdata_d[7:0] = mask_q;
				`IDX_UPDATE_STROBE, `IDX_EVENT_CONTROL, `IDX_EVENT_CLEAR:
					rdata_d = 32'h0000_0000;
				`IDX_MEMORY_STATUS: rdata_d[7:0] = snap_mem_q;
				`IDX_CLOCK_STATUS: rdata_d[7:0] = snap_clk_q;
				`IDX_DIGITAL_EVENTS: rdata_d[7:0] = snap_evt_q;
				default:
					if (ar_idx < `IDX_STATUS_FIRST || ar_idx > `IDX_STATUS_LAST)
						rresp_d = `RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && S_AXI_RREADY)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign S_AXI_ARREADY = !rvalid_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// decoded preset settings
	assign O_HIGH_MARGIN_FILTER_SELECT = settings_q[`FILTER_SEL_BIT];
	assign O_PHASE_MARGIN_TENTHS = settings_q[`FILTER_SEL_BIT] ?
		`MARGIN_HIGH_TENTHS_DEG : `MARGIN_NORMAL_TENTHS_DEG;
	assign O_LOOP_BANDWIDTH_CODE = settings_q[`BW_MSB:`BW_LSB];
	assign O_TOLERANCE_CODE = settings_q[`TOL_MSB:`TOL_LSB];

	always_comb
	begin
		unique case (settings_q[`BW_MSB:`BW_LSB])
			2'b00: O_LOOP_BANDWIDTH_HZ = `BW_CODE00_HZ;
			2'b01: O_LOOP_BANDWIDTH_HZ = `BW_CODE01_HZ;
			2'b10: O_LOOP_BANDWIDTH_HZ = `BW_CODE10_HZ;
			2'b11: O_LOOP_BANDWIDTH_HZ = `BW_CODE11_HZ;
		endcase
		unique case (settings_q[`TOL_MSB:`TOL_LSB])
			2'b00:
			begin
				O_OUTER_TOLERANCE_PPB = `OUTER_TOL00_PPB;
				O_INNER_TOLERANCE_PPB = `INNER_TOL00_PPB;
			end
			2'b01:
			begin
				O_OUTER_TOLERANCE_PPB = `OUTER_TOL01_PPB;
				O_INNER_TOLERANCE_PPB = `INNER_TOL01_PPB;
			end
			2'b10:
			begin
				O_OUTER_TOLERANCE_PPB = `OUTER_TOL10_PPB;
				O_INNER_TOLERANCE_PPB = `INNER_TOL10_PPB;
			end
			2'b11:
			begin
				O_OUTER_TOLERANCE_PPB = `OUTER_TOL11_PPB;
				O_INNER_TOLERANCE_PPB = `INNER_TOL11_PPB;
			end
		endcase
	end

	assign O_ROM_LOAD_START = start_q;
	assign O_SOFT_RESET = soft_rst_q;
	assign O_ROM_BUSY = (rom_q == preset_status_pkg::ROM_BUSY);
endmodule

// File: tb/preset_config_status_readback_sva.sv
// checker for settings decode and ROM download trigger handshake
`include "preset_status_consts.svh"
module preset_config_status_readback_chk (
	input wire logic I_CLK, // clock
	input wire logic I_RST, // reset
	input wire logic I_ROM_DONE, // download finished
	input wire logic O_HIGH_MARGIN_FILTER_SELECT, // filter select
	input wire logic [11:0] O_PHASE_MARGIN_TENTHS, // margin
	input wire logic [1:0] O_LOOP_BANDWIDTH_CODE, // bandwidth code
	input wire logic [7:0] O_LOOP_BANDWIDTH_HZ, // bandwidth
	input wire logic [1:0] O_TOLERANCE_CODE, // tolerance code
	input wire logic [31:0] O_OUTER_TOLERANCE_PPB, // outer
	input wire logic [31:0] O_INNER_TOLERANCE_PPB, // inner
	input wire logic O_ROM_LOAD_START, // start pulse
	input wire logic O_SOFT_RESET, // soft reset pulse
	input wire logic O_ROM_BUSY, // download running
	input wire logic S_AXI_RVALID // read valid
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	logic [7:0] bw_tab [4];
	logic [31:0] out_tab [4];
	logic [31:0] in_tab [4];
	assign bw_tab = '{`BW_CODE00_HZ, `BW_CODE01_HZ, `BW_CODE10_HZ,
		`BW_CODE11_HZ};
	assign out_tab = '{`OUTER_TOL00_PPB, `OUTER_TOL01_PPB, `OUTER_TOL10_PPB,
		`OUTER_TOL11_PPB};
	assign in_tab = '{`INNER_TOL00_PPB, `INNER_TOL01_PPB, `INNER_TOL10_PPB,
		`INNER_TOL11_PPB};
	property p_margin;
		O_PHASE_MARGIN_TENTHS == (O_HIGH_MARGIN_FILTER_SELECT ?
			`MARGIN_HIGH_TENTHS_DEG : `MARGIN_NORMAL_TENTHS_DEG);
	endproperty
	property p_bw;
		O_LOOP_BANDWIDTH_HZ == bw_tab[O_LOOP_BANDWIDTH_CODE];
	endproperty
	property p_outer;
		O_OUTER_TOLERANCE_PPB == out_tab[O_TOLERANCE_CODE];
	endproperty
	property p_inner;
		O_INNER_TOLERANCE_PPB == in_tab[O_TOLERANCE_CODE];
	endproperty
	// one start pulse per download, launched with the busy flag
	property p_start;
		O_ROM_LOAD_START |-> $rose(O_ROM_BUSY) ##1 !O_ROM_LOAD_START;
	endproperty
	property p_hold;
		O_ROM_BUSY && !I_ROM_DONE |=> O_ROM_BUSY;
	endproperty
	property p_done;
		O_ROM_BUSY && I_ROM_DONE |=> !O_ROM_BUSY;
	endproperty
	property p_soft;
		O_SOFT_RESET |-> O_ROM_LOAD_START;
	endproperty
	a_margin: assert property (p_margin) else $error("margin decode");
	a_bw: assert property (p_bw) else $error("bandwidth decode");
	a_outer: assert property (p_outer) else $error("outer decode");
	a_inner: assert property (p_inner) else $error("inner decode");
	a_start: assert property (p_start) else $error("start pulse");
	a_hold: assert property (p_hold) else $error("busy dropped");
	a_done: assert property (p_done) else $error("busy stuck");
	a_soft: assert property (p_soft) else $error("soft reset alone");
	c_soft: cover property (O_SOFT_RESET);
	c_done: cover property (O_ROM_BUSY && I_ROM_DONE);
	c_read: cover property (S_AXI_RVALID);
endmodule
bind preset_config_status_readback preset_config_status_readback_chk i_chk (
	.I_CLK(I_CLK),
	.I_RST(I_RST),
	.I_ROM_DONE(I_ROM_DONE),
	.O_HIGH_MARGIN_FILTER_SELECT(O_HIGH_MARGIN_FILTER_SELECT),
	.O_PHASE_MARGIN_TENTHS(O_PHASE_MARGIN_TENTHS),
	.O_LOOP_BANDWIDTH_CODE(O_LOOP_BANDWIDTH_CODE),
	.O_LOOP_BANDWIDTH_HZ(O_LOOP_BANDWIDTH_HZ),
	.O_TOLERANCE_CODE(O_TOLERANCE_CODE),
	.O_OUTER_TOLERANCE_PPB(O_OUTER_TOLERANCE_PPB),
	.O_INNER_TOLERANCE_PPB(O_INNER_TOLERANCE_PPB),
	.O_ROM_LOAD_START(O_ROM_LOAD_START),
	.O_SOFT_RESET(O_SOFT_RESET),
	.O_ROM_BUSY(O_ROM_BUSY),
	.S_AXI_RVALID(S_AXI_RVALID)
);

// File: tb/preset_config_status_readback_test.sv
// self-checking bench: settings, ROM triggers, status snapshots, events
`include "preset_status_consts.svh"
`define CHK(a, b) check_val(32'(a), 32'(b))
module preset_config_status_readback_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic [15:0] S_AXI_AWADDR = 16'h0000;
	logic [15:0] S_AXI_ARADDR = 16'h0000;
	logic [31:0] S_AXI_WDATA = 32'h0000_0000;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, I_ROM_DONE = 1'b0;
	logic [5:0] live = 6'h00;
	logic [2:0] nvm = 3'h0;
	logic [7:0] I_DIGITAL_LOOP_EVENTS = 8'h00;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, O_HIGH_MARGIN_FILTER_SELECT, O_ROM_LOAD_START;
	logic O_SOFT_RESET, O_ROM_BUSY;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, O_LOOP_BANDWIDTH_CODE;
	logic [1:0] O_TOLERANCE_CODE;
	logic [31:0] S_AXI_RDATA, O_OUTER_TOLERANCE_PPB, O_INNER_TOLERANCE_PPB;
	logic [11:0] O_PHASE_MARGIN_TENTHS;
	logic [7:0] O_LOOP_BANDWIDTH_HZ;
	logic [7:0] bw [4] = '{8'h32, 8'h01, 8'h0A, 8'h64};
	logic [31:0] outer [4] = '{32'h05F5_E100, 32'h0000_2EE0, 32'h0000_BB80,
		32'h0003_0D40};
	logic [31:0] inner [4] = '{32'h04C4_B400, 32'h0000_2580, 32'h0000_9470,
		32'h0002_7100};
	int miscompares = 0, n_checks = 0, cycles = 0, n_start = 0, n_soft = 0;
	preset_config_status_readback i_preset_config_status_readback (
		.I_CLK, .I_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
		.S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
		.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
		.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .I_ROM_DONE,
		.I_NVM_LOAD_BUSY(nvm[1]), .I_NVM_SAVE_BUSY(nvm[0]),
		.I_NVM_FAULT(nvm[2]), .I_MULTIPLIER_LOCK(live[5]),
		.I_OUTPUT_LOOP_LOCK(live[4]), .I_DIGITAL_LOOP_LOCK(live[3]),
		.I_OUTPUT_OSCILLATOR_OK(live[2]),
		.I_OUTPUT_LOOP_CALIBRATING(live[1]),
		.I_STABILITY_TIMER_EXPIRED(live[0]), .I_DIGITAL_LOOP_EVENTS,
		.O_HIGH_MARGIN_FILTER_SELECT, .O_PHASE_MARGIN_TENTHS,
		.O_LOOP_BANDWIDTH_CODE, .O_LOOP_BANDWIDTH_HZ, .O_TOLERANCE_CODE,
		.O_OUTER_TOLERANCE_PPB, .O_INNER_TOLERANCE_PPB, .O_ROM_LOAD_START,
		.O_SOFT_RESET, .O_ROM_BUSY);
	always #50 I_CLK = ~I_CLK;
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// pulses are counted mid-cycle, away from the edge that moves them
	always @(negedge I_CLK)
	begin
		n_start += O_ROM_LOAD_START;
		n_soft += O_SOFT_RESET;
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			test_done();
		end
	end
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d,
		input logic [1:0] er = 2'h0);
		logic aw_p, w_p, a, w;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge I_CLK);
		S_AXI_AWADDR <= {2'b00, idx, 2'b00};
		S_AXI_WDATA <= {24'h00_0000, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		// readies are combinational, so look at them before the edge
		while (aw_p || w_p)
		begin
			@(negedge I_CLK);
			a = S_AXI_AWREADY;
			w = S_AXI_WREADY;
			@(posedge I_CLK);
			if (aw_p && a === 1'b1)
			begin
				S_AXI_AWVALID <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_p && w === 1'b1)
			begin
				S_AXI_WVALID <= 1'b0;
				w_p = 1'b0;
			end
		end
		do @(negedge I_CLK); while (S_AXI_BVALID !== 1'b1);
		`CHK(S_AXI_BRESP, er);
		@(posedge I_CLK);
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] idx, input logic [7:0] ed,
		input logic [1:0] er = 2'h0);
		@(posedge I_CLK);
		S_AXI_ARADDR <= {2'b00, idx, 2'b00};
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge I_CLK); while (S_AXI_ARREADY !== 1'b1);
		@(posedge I_CLK);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge I_CLK); while (S_AXI_RVALID !== 1'b1);
		`CHK(S_AXI_RDATA, {24'h00_0000, ed});
		`CHK(S_AXI_RRESP, er);
		@(posedge I_CLK);
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic pulse(input logic [7:0] ev, input logic dn);
		@(posedge I_CLK);
		I_DIGITAL_LOOP_EVENTS <= ev;
		I_ROM_DONE <= dn;
		@(posedge I_CLK);
		I_DIGITAL_LOOP_EVENTS <= 8'h00;
		I_ROM_DONE <= 1'b0;
	endtask
	// live bits: multiplier, output loop, digital loop, oscillator, cal, stable
	function automatic logic [7:0] cs(input logic [5:0] v);
		return {1'b0, v[4] & v[3], v[5] & v[4] & v[3], v[2], v[1], v[4],
			v[0], v[5]};
	endfunction
	initial
	begin
		repeat (20) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd(`IDX_PRESET_LOOP_SETTINGS, 8'h00);
		for (int i = 0; i < 32; i++)
		begin
			wr(`IDX_PRESET_LOOP_SETTINGS, {3'b111, 5'(i)});
			rd(`IDX_PRESET_LOOP_SETTINGS, 8'(i));
			@(negedge I_CLK);
			`CHK(O_PHASE_MARGIN_TENTHS, i[4] ? 12'h375 : 12'h2BC);
			`CHK(O_HIGH_MARGIN_FILTER_SELECT, i[4]);
			`CHK(O_LOOP_BANDWIDTH_CODE, i[3:2]);
			`CHK(O_TOLERANCE_CODE, i[1:0]);
			`CHK(O_LOOP_BANDWIDTH_HZ, bw[i[3:2]]);
			`CHK(O_OUTER_TOLERANCE_PPB, outer[i[1:0]]);
			`CHK(O_INNER_TOLERANCE_PPB, inner[i[1:0]]);
		end
		for (int t = 0; t < 2; t++)
		begin
			wr(`IDX_PRESET_LOAD_TRIGGER + 12'(t), 8'h01);
			@(negedge I_CLK);
			`CHK(O_ROM_BUSY, 1'b1);
			`CHK(n_start, t + 1);
			`CHK(n_soft, t);
			wr(`IDX_UPDATE_STROBE, 8'h01);
			rd(`IDX_MEMORY_STATUS, 8'h08);
			rd(`IDX_PRESET_LOAD_TRIGGER + 12'(t), 8'h01);
			pulse(8'h00, 1'b1);
			rd(`IDX_PRESET_LOAD_TRIGGER + 12'(t), 8'h00);
			@(negedge I_CLK);
			`CHK(O_ROM_BUSY, 1'b0);
			rd(`IDX_PRESET_LOOP_SETTINGS, 8'h1F);
		end
		// a write with its low byte lane off is answered but changes nothing
		S_AXI_WSTRB <= 4'h0;
		wr(`IDX_PRESET_LOOP_SETTINGS, 8'h00);
		S_AXI_WSTRB <= 4'hF;
		rd(`IDX_PRESET_LOOP_SETTINGS, 8'h1F);
		for (int i = 0; i < 64; i++)
		begin
			@(posedge I_CLK);
			live <= 6'(i);
			nvm <= 3'(i);
			wr(`IDX_UPDATE_STROBE, 8'h01);
			live <= ~6'(i);
			wr(`IDX_UPDATE_STROBE, 8'h02);
			wr(`IDX_CLOCK_STATUS, 8'hFF);
			rd(`IDX_MEMORY_STATUS, {5'h00, 3'(i)});
			rd(`IDX_CLOCK_STATUS, cs(6'(i)));
		end
		pulse(8'hA5, 1'b0);
		wr(`IDX_UPDATE_STROBE, 8'h01);
		rd(`IDX_DIGITAL_EVENTS, 8'hA5);
		wr(`IDX_EVENT_MASK, 8'h0F);
		rd(`IDX_EVENT_MASK, 8'h0F);
		pulse(8'hFF, 1'b0);
		wr(`IDX_UPDATE_STROBE, 8'h01);
		rd(`IDX_DIGITAL_EVENTS, 8'hF5);
		wr(`IDX_UPDATE_STROBE, 8'h01);
		rd(`IDX_DIGITAL_EVENTS, 8'hF5);
		wr(`IDX_EVENT_CLEAR, 8'h05);
		wr(`IDX_UPDATE_STROBE, 8'h01);
		rd(`IDX_DIGITAL_EVENTS, 8'hF0);
		wr(`IDX_EVENT_CONTROL, 8'h02);
		wr(`IDX_UPDATE_STROBE, 8'h01);
		rd(`IDX_DIGITAL_EVENTS, 8'h00);
		wr(12'h123, 8'h55, 2'h2);
		rd(12'h123, 8'h00, 2'h2);
		test_done();
	end
endmodule
